// ===== uli_consts.svh
// uli_consts.svh - offsets, field positions, reset values and counts of the serial line port
`ifndef ULI_CONSTS_SVH
`define ULI_CONSTS_SVH

// register byte offsets on the apb bus
`define ULI_OFF_CTRL 32'h0000_0000
`define ULI_OFF_BAUD 32'h0000_0004
`define ULI_OFF_TXD 32'h0000_0008
`define ULI_OFF_RXD 32'h0000_000c
`define ULI_OFF_STAT 32'h0000_0010

// control register bit positions
`define ULI_C_TX_EN 0
`define ULI_C_RX_EN 1
`define ULI_C_LOOP 2
`define ULI_C_CTS_EN 3
`define ULI_C_AUTO_RTS 4
`define ULI_C_RTS_SW 5
`define ULI_C_STOP 6
`define ULI_C_LVL_LO 8
`define ULI_C_LVL_HI 10

// status register bit positions
`define ULI_S_CNT_HI 2
`define ULI_S_BUSY 3
`define ULI_S_FULL 4
`define ULI_S_OVR 5
`define ULI_S_FERR 6
`define ULI_S_CTS 7
`define ULI_S_STOPPED 8
`define ULI_S_RTS 9

// reset values
`define ULI_BAUD_RST 16'h000d
`define ULI_LVL_RST 3'h3

// timing counts and queue depth: 16 ticks per bit, two ticks per serial clock period
`define ULI_FALL_LAST 3'h7
`define ULI_TICK_LAST 4'hf
`define ULI_TICK_MID 4'h7
`define ULI_BIT_LAST 3'h7
`define ULI_QDEPTH 3'h4

`endif

// ===== uli_pkg.sv
// uli_pkg.sv - types shared by the serial line port
`default_nettype none
package uli_pkg;

  // one-hot frame phase, used by both shifters
  typedef enum logic [3:0] {
    ULI_IDLE = 4'h1,
    ULI_START = 4'h2,
    ULI_DATA = 4'h4,
    ULI_STOP = 4'h8
  } uli_phase_e;

  // apb request as seen by the slave
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } uli_apb_req_s;

  // every flip-flop of the port
  typedef struct packed {
    logic tx_en;              // transmitter on
    logic rx_en;              // receiver on
    logic loop;               // local loopback
    logic cts_en;             // honour clear to send
    logic auto_rts;           // rts follows queue level
    logic rts_sw;             // software rts, 1 = assert
    logic stopped;            // port clock halted
    logic [2:0] rts_lvl;      // queue level that drops rts
    logic [15:0] div;         // tick divisor
    logic [15:0] div_cnt;     // divider count
    logic sclk;               // serial clock phase
    uli_phase_e tx_st;
    logic [2:0] tx_fall;      // falls within a bit
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_full;            // char loaded, held until its stop bit ends
    logic tx_int;             // internal line, feeds loopback
    logic tx_pin;             // pin flop
    uli_phase_e rx_st;
    logic [3:0] rx_tick;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_prev;            // last pin level, for wake
    logic [3:0][7:0] q;       // receive queue storage
    logic [1:0] wp;
    logic [1:0] rp;
    logic [2:0] cnt;
    logic ovr;                // sticky overrun
    logic ferr;               // sticky framing error
    logic rts_n;              // rts pin flop
    logic [31:0] rdata;       // read data flop
  } uli_state_s;

endpackage : uli_pkg
`default_nettype wire

// ===== uli_uart.sv
// uli_uart.sv - serial line port with apb registers, lsb-first shifters and rts/cts flow control
//
// Functional notes
// - tx line high when disabled, idle, loopback
// - transmit lsb first, change on falling edge
// - receive assembles characters lsb first
// - rx line transition restarts stopped port clock
// - clear to send permits transmission start
// - rts pin under hardware or software control
// - rts optionally follows receive queue level
`include "uli_consts.svh"
`default_nettype none
module uli_uart (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic serial_tx_line,
  input wire logic serial_rx_line,
  input wire logic clear_to_send_in_n,
  output logic request_to_send_out_n
);

  // exact address match, used by every decode
  function automatic logic uli_hit(input logic [31:0] a, input logic [31:0] off);
    uli_hit = (a == off);
  endfunction : uli_hit

  uli_pkg::uli_state_s st_q;  // all state
  uli_pkg::uli_state_s st_d;  // next state
  uli_pkg::uli_apb_req_s req; // bundled bus request
  logic tick_w;               // divider tick, twice per serial clock
  logic fall_w;               // falling edge of serial clock
  logic rx_src_w;             // pin or loopback
  logic rx_samp_w;            // data bit sampled this cycle
  logic tx_may_w;             // pin allowed to change
  logic tx_lsb_w;             // first data bit
  logic wr_w;                 // write completes
  logic rd_w;                 // read completes
  logic mapped_w;             // address decodes

  assign req = '{psel, penable, pwrite, paddr, pwdata};
  assign tick_w = !st_q.stopped && (st_q.div_cnt == st_q.div);
  assign fall_w = tick_w && st_q.sclk;
  assign rx_src_w = st_q.loop ? st_q.tx_int : serial_rx_line;
  assign rx_samp_w = tick_w && (st_q.rx_st == uli_pkg::ULI_DATA) && (st_q.rx_tick == `ULI_TICK_LAST);
  assign tx_may_w = fall_w || !st_q.tx_en || st_q.loop;
  assign tx_lsb_w = st_q.tx_sh[0];
  assign wr_w = req.psel && req.penable && req.pwrite;
  assign rd_w = req.psel && req.penable && !req.pwrite;
  assign mapped_w = uli_hit(req.paddr, `ULI_OFF_CTRL) || uli_hit(req.paddr, `ULI_OFF_BAUD) ||
                    uli_hit(req.paddr, `ULI_OFF_TXD) || uli_hit(req.paddr, `ULI_OFF_RXD) ||
                    uli_hit(req.paddr, `ULI_OFF_STAT);

  // zero-wait slave; read data was caught in the setup cycle
  assign pready = 1'b1;
  assign pslverr = req.psel && req.penable && !mapped_w;
  assign prdata = st_q.rdata;
  assign serial_tx_line = st_q.tx_pin;
  assign request_to_send_out_n = st_q.rts_n;

  // next-state logic for bus, divider, shifters and flow control
  always_comb begin
    st_d = st_q;
    // divider runs only while the port clock is alive
    if (!st_q.stopped) begin
      st_d.div_cnt = tick_w ? 16'h0000 : st_q.div_cnt + 16'h0001;
    end
    if (tick_w) begin
      st_d.sclk = !st_q.sclk;
    end
    // an rx pin edge wakes a stopped port, even over a stop write in the same cycle; a port stopped from running this cycle stays stopped
    st_d.rx_prev = serial_rx_line;

    // setup cycle: capture read data so prdata is a flop
    if (req.psel && !req.penable) begin
      st_d.rdata = 32'h0000_0000;
      if (uli_hit(req.paddr, `ULI_OFF_CTRL)) begin
        st_d.rdata[`ULI_C_TX_EN] = st_q.tx_en;
        st_d.rdata[`ULI_C_RX_EN] = st_q.rx_en;
        st_d.rdata[`ULI_C_LOOP] = st_q.loop;
        st_d.rdata[`ULI_C_CTS_EN] = st_q.cts_en;
        st_d.rdata[`ULI_C_AUTO_RTS] = st_q.auto_rts;
        st_d.rdata[`ULI_C_RTS_SW] = st_q.rts_sw;
        st_d.rdata[`ULI_C_STOP] = st_q.stopped;
        st_d.rdata[`ULI_C_LVL_HI:`ULI_C_LVL_LO] = st_q.rts_lvl;
      end else if (uli_hit(req.paddr, `ULI_OFF_BAUD)) begin
        st_d.rdata[15:0] = st_q.div;
      end else if (uli_hit(req.paddr, `ULI_OFF_RXD)) begin
        st_d.rdata[7:0] = st_q.q[st_q.rp];
      end else if (uli_hit(req.paddr, `ULI_OFF_STAT)) begin
        st_d.rdata[`ULI_S_CNT_HI:0] = st_q.cnt;
        st_d.rdata[`ULI_S_BUSY] = (st_q.tx_st != uli_pkg::ULI_IDLE) || st_q.tx_full;
        st_d.rdata[`ULI_S_FULL] = st_q.tx_full;
        st_d.rdata[`ULI_S_OVR] = st_q.ovr;
        st_d.rdata[`ULI_S_FERR] = st_q.ferr;
        st_d.rdata[`ULI_S_CTS] = !clear_to_send_in_n;
        st_d.rdata[`ULI_S_STOPPED] = st_q.stopped;
        st_d.rdata[`ULI_S_RTS] = !st_q.rts_n;
      end
    end

    // access cycle writes
    if (wr_w) begin
      if (uli_hit(req.paddr, `ULI_OFF_CTRL)) begin
        st_d.tx_en = req.pwdata[`ULI_C_TX_EN];
        st_d.rx_en = req.pwdata[`ULI_C_RX_EN];
        st_d.loop = req.pwdata[`ULI_C_LOOP];
        st_d.cts_en = req.pwdata[`ULI_C_CTS_EN];
        st_d.auto_rts = req.pwdata[`ULI_C_AUTO_RTS];
        st_d.rts_sw = req.pwdata[`ULI_C_RTS_SW];
        st_d.stopped = req.pwdata[`ULI_C_STOP];
        st_d.rts_lvl = req.pwdata[`ULI_C_LVL_HI:`ULI_C_LVL_LO];
      end else if (uli_hit(req.paddr, `ULI_OFF_BAUD)) begin
        st_d.div = req.pwdata[15:0];
        st_d.div_cnt = 16'h0000;
      end else if (uli_hit(req.paddr, `ULI_OFF_TXD) && !st_q.tx_full) begin
        // a write while a char is waiting or still being sent is dropped
        st_d.tx_sh = req.pwdata[7:0];
        st_d.tx_full = 1'b1;
      end else if (uli_hit(req.paddr, `ULI_OFF_STAT)) begin
        // write one to clear the sticky errors
        if (req.pwdata[`ULI_S_OVR]) st_d.ovr = 1'b0;
        if (req.pwdata[`ULI_S_FERR]) st_d.ferr = 1'b0;
      end
    end
    if (st_q.stopped && (serial_rx_line != st_q.rx_prev)) begin
      st_d.stopped = 1'b0;
    end

    // reading the data register pops one character
    if (rd_w && uli_hit(req.paddr, `ULI_OFF_RXD) && (st_q.cnt != 3'h0)) begin
      st_d.rp = st_q.rp + 2'h1;
      st_d.cnt = st_q.cnt - 3'h1;
    end

    // transmit shifter steps on serial clock falls only
    if (fall_w) begin
      case (st_q.tx_st)
        uli_pkg::ULI_IDLE: begin
          if (st_q.tx_full && (!st_q.cts_en || !clear_to_send_in_n)) begin
            st_d.tx_st = uli_pkg::ULI_START;
            st_d.tx_int = 1'b0;
            st_d.tx_fall = 3'h0;
          end
        end
        uli_pkg::ULI_START: begin
          st_d.tx_fall = st_q.tx_fall + 3'h1;
          if (st_q.tx_fall == `ULI_FALL_LAST) begin
            st_d.tx_st = uli_pkg::ULI_DATA;
            st_d.tx_int = st_q.tx_sh[0];
            st_d.tx_bit = 3'h0;
          end
        end
        uli_pkg::ULI_DATA: begin
          st_d.tx_fall = st_q.tx_fall + 3'h1;
          if (st_q.tx_fall == `ULI_FALL_LAST) begin
            st_d.tx_sh = {1'b0, st_q.tx_sh[7:1]};
            st_d.tx_bit = st_q.tx_bit + 3'h1;
            if (st_q.tx_bit == `ULI_BIT_LAST) begin
              st_d.tx_st = uli_pkg::ULI_STOP;
              st_d.tx_int = 1'b1;
            end else begin
              st_d.tx_int = st_q.tx_sh[1];
            end
          end
        end
        uli_pkg::ULI_STOP: begin
          st_d.tx_fall = st_q.tx_fall + 3'h1;
          if (st_q.tx_fall == `ULI_FALL_LAST) begin
            st_d.tx_st = uli_pkg::ULI_IDLE;
            st_d.tx_full = 1'b0;
          end
        end
        default: begin
          st_d.tx_st = uli_pkg::ULI_IDLE;
        end
      endcase
    end
    // disabling aborts a frame; the char is lost on purpose
    if (!st_q.tx_en) begin
      st_d.tx_st = uli_pkg::ULI_IDLE;
      st_d.tx_int = 1'b1;
      st_d.tx_full = 1'b0;
    end
    // pin sits at mark unless a live, non-loopback frame drives it
    st_d.tx_pin = (st_q.tx_en && !st_q.loop) ? st_d.tx_int : 1'b1;

    // receive shifter, 16 ticks per bit, mid-bit sampling
    if (tick_w) begin
      case (st_q.rx_st)
        uli_pkg::ULI_IDLE: begin
          if (st_q.rx_en && !rx_src_w) begin
            st_d.rx_st = uli_pkg::ULI_START;
            st_d.rx_tick = 4'h0;
          end
        end
        uli_pkg::ULI_START: begin
          st_d.rx_tick = st_q.rx_tick + 4'h1;
          if (st_q.rx_tick == `ULI_TICK_MID) begin
            // a glitch shorter than half a bit is not a start
            st_d.rx_st = rx_src_w ? uli_pkg::ULI_IDLE : uli_pkg::ULI_DATA;
            st_d.rx_tick = 4'h0;
            st_d.rx_bit = 3'h0;
          end
        end
        uli_pkg::ULI_DATA: begin
          st_d.rx_tick = st_q.rx_tick + 4'h1;
          if (st_q.rx_tick == `ULI_TICK_LAST) begin
            st_d.rx_sh = {rx_src_w, st_q.rx_sh[7:1]};
            st_d.rx_bit = st_q.rx_bit + 3'h1;
            if (st_q.rx_bit == `ULI_BIT_LAST) st_d.rx_st = uli_pkg::ULI_STOP;
          end
        end
        uli_pkg::ULI_STOP: begin
          st_d.rx_tick = st_q.rx_tick + 4'h1;
          if (st_q.rx_tick == `ULI_TICK_LAST) begin
            st_d.rx_st = uli_pkg::ULI_IDLE;
            if (!rx_src_w) begin
              st_d.ferr = 1'b1;
            end else if (st_d.cnt == `ULI_QDEPTH) begin
              st_d.ovr = 1'b1;
            end else begin
              st_d.q[st_q.wp] = st_q.rx_sh;
              st_d.wp = st_q.wp + 2'h1;
              st_d.cnt = st_d.cnt + 3'h1;
            end
          end
        end
        default: begin
          st_d.rx_st = uli_pkg::ULI_IDLE;
        end
      endcase
    end

    // rts: queue level in auto mode, software bit otherwise
    if (st_q.auto_rts) begin
      st_d.rts_n = (st_d.cnt >= st_q.rts_lvl);
    end else begin
      st_d.rts_n = !st_q.rts_sw;
    end
  end

  // register the whole state; reset leaves the line at mark
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= '0;
      st_q.rts_lvl <= `ULI_LVL_RST;
      st_q.div <= `ULI_BAUD_RST;
      st_q.tx_st <= uli_pkg::ULI_IDLE;
      st_q.rx_st <= uli_pkg::ULI_IDLE;
      st_q.tx_int <= 1'b1;
      st_q.tx_pin <= 1'b1;
      st_q.rx_prev <= 1'b1;
      st_q.rts_n <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // checks on the line behaviour
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_TX_MARK: assert property ((!st_q.tx_en || st_q.loop) |=> serial_tx_line)
    else $error("tx line not at mark while off or looped");
  AST_TX_FALL: assert property ($changed(serial_tx_line) |-> $past(tx_may_w))
    else $error("tx line moved off a serial clock fall");
  AST_TX_LSB: assert property ((st_q.tx_st == uli_pkg::ULI_START && fall_w && st_q.tx_fall == 3'h7
    && st_q.tx_en && !st_q.loop) |=> serial_tx_line == $past(tx_lsb_w))
    else $error("first data bit is not the lsb");
  AST_RX_LSB: assert property (rx_samp_w |=> st_q.rx_sh[7] == $past(rx_src_w))
    else $error("received bit not shifted in at the top");
  AST_WAKE: assert property ((st_q.stopped && serial_rx_line != st_q.rx_prev) |=> !st_q.stopped)
    else $error("rx edge did not restart the port clock");
  AST_CTS: assert property ((st_q.tx_st == uli_pkg::ULI_IDLE && st_q.cts_en && clear_to_send_in_n)
    |=> st_q.tx_st == uli_pkg::ULI_IDLE)
    else $error("frame started without clear to send");
  AST_RTS_SW: assert property ((!st_q.auto_rts && st_q.rts_sw) |=> !request_to_send_out_n)
    else $error("software rts not on the pin");
  // the pin follows the count after any pop or push of the same cycle, so compare against the new count
  AST_RTS_AUTO: assert property (st_q.auto_rts
    |=> request_to_send_out_n == (st_q.cnt >= $past(st_q.rts_lvl)))
    else $error("rts does not follow the queue level");
  AST_START_LOW: assert property ((st_q.tx_st == uli_pkg::ULI_START) |-> !st_q.tx_int)
    else $error("start bit not low");
  AST_STOP_HIGH: assert property ((st_q.tx_st == uli_pkg::ULI_STOP) |-> st_q.tx_int)
    else $error("stop bit not high");

  COV_TX_DONE: cover property (st_q.tx_st == uli_pkg::ULI_STOP ##1 st_q.tx_st == uli_pkg::ULI_IDLE);
  COV_RX_PUSH: cover property (st_q.rx_st == uli_pkg::ULI_STOP ##1 $rose(st_q.cnt != 3'h0));
  COV_WAKE: cover property ($fell(st_q.stopped));
  COV_RTS_AUTO: cover property (st_q.auto_rts && $rose(request_to_send_out_n));

endmodule : uli_uart
`default_nettype wire

// ===== uli_remote.sv
// uli_remote.sv - behavioural remote serial device facing the port
`default_nettype none
module uli_remote #(
  parameter int BIT_CLKS = 16
) (
  input wire logic mclk,
  input wire logic serial_tx_line,
  output logic serial_rx_line,
  output logic clear_to_send_in_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // line idles at mark, port is cleared to send by default
  initial begin
    serial_rx_line = 1'b1;
    clear_to_send_in_n = 1'b0;
  end
  // flow control seen by the port, low means go
  task automatic set_cts(input logic go);
    clear_to_send_in_n <= !go;
  endtask : set_cts
  // one 8n1 frame, lsb first, whole bit times only
  task automatic send_char(input logic [7:0] c);
    logic [9:0] fr;
    fr = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      serial_rx_line <= fr[i];
      repeat (BIT_CLKS) @(posedge mclk);
    end
  endtask : send_char
  // a frame with a low stop bit, then a bit time of mark so no false start follows
  task automatic send_bad_stop(input logic [7:0] c);
    logic [9:0] fr;
    fr = {1'b0, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      serial_rx_line <= fr[i];
      repeat (BIT_CLKS) @(posedge mclk);
    end
    serial_rx_line <= 1'b1;
    repeat (BIT_CLKS) @(posedge mclk);
  endtask : send_bad_stop
  // wait for a start bit, sample mid-bit; ok is low on bad start or stop
  task automatic recv_char(output logic [7:0] c, output logic ok);
    int n;
    c = 8'h00;
    ok = 1'b0;
    n = 0;
    while (serial_tx_line !== 1'b0 && n < 4000) begin
      @(posedge mclk);
      n++;
    end
    if (n < 4000) begin
      repeat (BIT_CLKS / 2) @(posedge mclk);
      ok = (serial_tx_line === 1'b0);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CLKS) @(posedge mclk);
        c[i] = serial_tx_line;
      end
      repeat (BIT_CLKS) @(posedge mclk);
      ok = ok && (serial_tx_line === 1'b1);
    end
  endtask : recv_char
endmodule : uli_remote
`default_nettype wire

// ===== uart_line_interface_test.sv
// uart_line_interface_test.sv - self-checking bench for the serial line port
`include "uli_consts.svh"
`default_nettype none
module uart_line_interface_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic serial_tx_line;
  logic serial_rx_line;
  logic clear_to_send_in_n;
  logic request_to_send_out_n;
  int n_errors = 0;
  int n_checks = 0;
  logic [31:0] d;
  logic e;
  logic [7:0] c;
  logic ok;
  // 25 mhz clock
  always #20 mclk = ~mclk;
  uli_uart uut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_tx_line(serial_tx_line),
    .serial_rx_line(serial_rx_line), .clear_to_send_in_n(clear_to_send_in_n),
    .request_to_send_out_n(request_to_send_out_n));
  // divisor 0 gives 16 mclk per bit, matching the model
  uli_remote #(.BIT_CLKS(16)) remote (.mclk(mclk), .serial_tx_line(serial_tx_line),
    .serial_rx_line(serial_rx_line), .clear_to_send_in_n(clear_to_send_in_n));
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; an idle edge follows so the next setup is a fresh assignment
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 16) begin
      n_errors++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic wr(input logic [31:0] a, input logic [31:0] wd);
    logic [31:0] x;
    logic y;
    apb(1'b1, a, wd, x, y);
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] x);
    logic y;
    apb(1'b0, a, 32'h0, x, y);
  endtask : rd
  // transmit line must stay at mark for the whole span
  task automatic hold_high(input int cycles);
    logic all_high;
    all_high = 1'b1;
    repeat (cycles) begin
      @(posedge mclk);
      all_high = all_high && (serial_tx_line === 1'b1);
    end
    chk({31'h0, all_high}, 32'h1);
  endtask : hold_high
  // reset values and an unmapped access
  task automatic t_reset;
    chk({31'h0, serial_tx_line}, 32'h1);
    chk({31'h0, request_to_send_out_n}, 32'h1);
    rd(`ULI_OFF_CTRL, d);
    chk(d, 32'h0000_0300);
    rd(`ULI_OFF_BAUD, d);
    chk(d, 32'h0000_000d);
    apb(1'b0, 32'h0000_0014, 32'h0, d, e);
    chk({31'h0, e}, 32'h1);
    chk(d, 32'h0);
    $display("test reset done");
  endtask : t_reset
  // one frame out, bit order checked by the remote
  task automatic t_tx;
    wr(`ULI_OFF_BAUD, 32'h0);
    wr(`ULI_OFF_CTRL, 32'h1);
    hold_high(40);
    fork
      remote.recv_char(c, ok);
      wr(`ULI_OFF_TXD, 32'h4b);
    join
    chk({24'h0, c}, 32'h4b);
    chk({31'h0, ok}, 32'h1);
    hold_high(40);
    $display("test tx done");
  endtask : t_tx
  // held by clear to send, then released
  task automatic t_cts;
    remote.set_cts(1'b0);
    wr(`ULI_OFF_CTRL, 32'h9);
    wr(`ULI_OFF_TXD, 32'h0e);
    hold_high(100);
    fork
      remote.recv_char(c, ok);
      remote.set_cts(1'b1);
    join
    chk({24'h0, c}, 32'h0e);
    $display("test cts done");
  endtask : t_cts
  // receive, rts from queue level 1, then software rts
  task automatic t_rx;
    wr(`ULI_OFF_CTRL, 32'h112);
    // the pin moves one edge after the mode bit lands; look once it has settled
    @(posedge mclk);
    chk({31'h0, request_to_send_out_n}, 32'h0);
    remote.send_char(8'h35);
    repeat (4) @(posedge mclk);
    rd(`ULI_OFF_STAT, d);
    chk(d & 32'h7, 32'h1);
    chk({31'h0, request_to_send_out_n}, 32'h1);
    rd(`ULI_OFF_RXD, d);
    chk(d, 32'h35);
    chk({31'h0, request_to_send_out_n}, 32'h0);
    // negate first, so the software assert is seen to move the pin
    wr(`ULI_OFF_CTRL, 32'h2);
    @(posedge mclk);
    chk({31'h0, request_to_send_out_n}, 32'h1);
    wr(`ULI_OFF_CTRL, 32'h22);
    @(posedge mclk);
    chk({31'h0, request_to_send_out_n}, 32'h0);
    $display("test rx done");
  endtask : t_rx
  // overrun on a full queue, framing error on a low stop, both cleared by writing one
  task automatic t_err;
    wr(`ULI_OFF_CTRL, 32'h2);
    for (int i = 0; i < 5; i++) begin
      remote.send_char(8'h11 + 8'(i));
    end
    repeat (4) @(posedge mclk);
    rd(`ULI_OFF_STAT, d);
    chk(d & 32'h67, 32'h24);
    wr(`ULI_OFF_STAT, 32'h20);
    rd(`ULI_OFF_STAT, d);
    chk(d & 32'h67, 32'h04);
    for (int i = 0; i < 4; i++) begin
      rd(`ULI_OFF_RXD, d);
      chk(d, 32'h11 + i);
    end
    remote.send_bad_stop(8'h77);
    repeat (4) @(posedge mclk);
    rd(`ULI_OFF_STAT, d);
    chk(d & 32'h67, 32'h40);
    wr(`ULI_OFF_STAT, 32'h40);
    rd(`ULI_OFF_STAT, d);
    chk(d & 32'h67, 32'h0);
    $display("test err done");
  endtask : t_err
  // stopped port clock woken by a start bit
  task automatic t_wake;
    wr(`ULI_OFF_CTRL, 32'h42);
    rd(`ULI_OFF_STAT, d);
    chk(d & 32'h100, 32'h100);
    remote.send_char(8'h5a);
    repeat (4) @(posedge mclk);
    rd(`ULI_OFF_STAT, d);
    chk(d & 32'h107, 32'h1);
    rd(`ULI_OFF_RXD, d);
    chk(d, 32'h5a);
    $display("test wake done");
  endtask : t_wake
  // loopback keeps the pin at mark while data goes round inside
  task automatic t_loop;
    wr(`ULI_OFF_CTRL, 32'h7);
    wr(`ULI_OFF_TXD, 32'h6c);
    hold_high(200);
    rd(`ULI_OFF_RXD, d);
    chk(d, 32'h6c);
    $display("test loop done");
  endtask : t_loop
  // reset for 10 cycles, then the scenarios in turn
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_tx();
    t_cts();
    t_rx();
    t_wake();
    t_err();
    t_loop();
    finish_test();
  end
endmodule : uart_line_interface_test
`default_nettype wire
